// ### src/urx_top.sv
// module: APB-reached asynchronous serial receive channel with snooze error handling
// Behaviour
// R1: bit time is 2*(divider+1) operation clock ticks.
// R2: software never programs divider zero or one; legal range 2..127.
// R3: select bit picks a 4-bit prescaler field c; op clock = clock / 2^c.
// R4: snooze with error enable clear: no error irq, done irq still raised.
// R5: snooze, error enable set, suppress clear: error irq on any error.
// R6: snooze with suppress set: errors set no flag and no error irq.
// R7: software stops channel before and after snooze, then clears wake bit.
// R8: with suppression, software clears flags and reads data before setting wake.
// R9: software reads snooze data while wake bit is still set.
// R10: latch points follow divider after the start edge; stop bit ends frame.
// R11: remote rate must stay within the receivable tolerance window.
// R12: reading the data register clears buffer full.
// R13: writing ones to flag clear register clears matching error flags.
// R14: stop bit clears enable status and halts the channel.
// R15: start bit sets enable status and enables the channel.
// R16: software halts all channels before changing the system clock.
// R17: armed snooze, device stopped: start edge begins reception unaided.
// R18: bit counter restarts at each start edge; low stop sample is framing error.
module urx_top #(
  parameter int PRS_W   = 4,
  parameter int DIV_W   = 7,
  parameter int DEPTH   = 2
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rx_pin,
  input  wire logic        device_stopped,
  output logic             rx_done_irq,
  output logic             rx_error_irq,
  output logic             snooze_wakeup
);
  import urx_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = (1 << PRS_W) - 1;

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  if (PRS_W != 4 || DIV_W != 7 || DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
    $error("urx_top: unsupported parameter values");
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0]       prs_q;
  logic [15:0]      mode_q;
  logic [DIV_W-1:0] div_q;
  logic [8:0]       rdata_q;
  logic             bff_q, ovr_q, par_q, frm_q;
  logic             en_q, wake_q, supp_q;
  logic             pready_q, pslverr_q;
  logic [31:0]      prdata_q;
  logic             done_irq_q, err_irq_q, wakeup_q;

  // apb decode: one wait state, request takes effect when pready is high
  wire acc     = psel & penable;
  wire fire    = acc & pready_q;
  wire wr_fire = fire & pwrite;
  wire rd_fire = fire & ~pwrite;
  wire hit_prs = (paddr == OFS_PRESCALER);
  wire hit_mod = (paddr == OFS_MODE);
  wire hit_dat = (paddr == OFS_DATA);
  wire hit_sts = (paddr == OFS_STATUS);
  wire hit_clr = (paddr == OFS_FLAGCLR);
  wire hit_sta = (paddr == OFS_START);
  wire hit_stp = (paddr == OFS_STOP);
  wire hit_ena = (paddr == OFS_ENABLE);
  wire hit_snz = (paddr == OFS_SNOOZE);
  wire mapped  = hit_prs | hit_mod | hit_dat | hit_sts | hit_clr | hit_sta | hit_stp
               | hit_ena | hit_snz;

  logic        busy;
  logic [31:0] rd_mux;
  // read data selection
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_prs) begin
      rd_mux[7:0] = prs_q;
    end else if (hit_mod) begin
      rd_mux[15:0] = mode_q;
    end else if (hit_dat) begin
      rd_mux[15:0] = {div_q, rdata_q};
    end else if (hit_sts) begin
      rd_mux[ST_OVR_BIT]  = ovr_q;
      rd_mux[ST_PAR_BIT]  = par_q;
      rd_mux[ST_FRM_BIT]  = frm_q;
      rd_mux[ST_BFF_BIT]  = bff_q;
      rd_mux[ST_BUSY_BIT] = busy;
    end else if (hit_ena) begin
      rd_mux[0] = en_q;
    end else if (hit_snz) begin
      rd_mux[SNZ_WAKE_BIT] = wake_q;
      rd_mux[SNZ_SUPP_BIT] = supp_q;
    end
  end
  // apb handshake and answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q  <= acc & ~pready_q;
      prdata_q  <= (acc & ~pready_q & ~pwrite) ? rd_mux : 32'h0000_0000;
      pslverr_q <= acc & ~pready_q & ~mapped;
    end
  end
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prs_q  <= RST_PRESCALER;
      mode_q <= RST_MODE;
      div_q  <= RST_DIVIDER;
      wake_q <= 1'b0;
      supp_q <= 1'b0;
    end else if (wr_fire) begin
      if (hit_prs) prs_q <= pwdata[7:0];
      if (hit_mod) mode_q <= pwdata[15:0];
      if (hit_dat) div_q <= pwdata[DIV_LSB +: DIV_W];
      if (hit_snz) begin
        wake_q <= pwdata[SNZ_WAKE_BIT];
        supp_q <= pwdata[SNZ_SUPP_BIT];
      end
    end
  end
  // channel enable: stop wins over start when both written
  wire stop_wr  = wr_fire & hit_stp & pwdata[0];
  wire start_wr = wr_fire & hit_sta & pwdata[0];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_q <= 1'b0;
    end else if (stop_wr) begin
      en_q <= 1'b0; // [R14]
    end else if (start_wr) begin
      en_q <= 1'b1; // [R15]
    end
  end

  // ****************************************************************
  // operation clock tick
  // ****************************************************************
  logic [CNT_W-1:0] pre_cnt_q;
  wire  [3:0]  prs_sel = mode_q[MODE_CKS_BIT] ? prs_q[PRS1_LSB +: 4]
                                              : prs_q[PRS0_LSB +: 4]; // [R3]
  wire  [CNT_W-1:0] pre_mask = CNT_W'((16'h0001 << prs_sel) - 16'h0001);
  wire  op_tick = &(pre_cnt_q | ~pre_mask); // one tick per 2^c clocks [R3]
  // free-running prescaler counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 1'b1;
    end
  end

  // ****************************************************************
  // receive pin synchroniser and start edge
  // ****************************************************************
  logic rx_s1_q, rx_s2_q, rx_s3_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      rx_s3_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
      rx_s3_q <= rx_s2_q;
    end
  end
  wire fall = rx_s3_q & ~rx_s2_q;

  // ****************************************************************
  // receiver state machine
  // ****************************************************************
  urx_state_e       st_q;
  logic [DIV_W:0]   tcnt_q;
  logic [3:0]       bit_q;
  logic [8:0]       shf_q;
  logic             pacc_q;
  logic             pbad_q;
  wire  [1:0]       pmode  = mode_q[MODE_PAR_LSB +: 2];
  wire  [3:0]       nbits  = mode_q[MODE_LEN9_BIT] ? 4'd9 : 4'd8;
  wire  [DIV_W:0]   half   = {1'b0, div_q};          // k ticks less one [R10]
  wire  [DIV_W:0]   full   = {div_q, 1'b1};          // 2k ticks less one [R1]
  wire  [DIV_W:0]   tgt    = (st_q == URX_START) ? half : full;
  wire              latch  = op_tick & (tcnt_q == tgt);
  wire              frame_end = latch & (st_q == URX_STOP);
  wire              odd_ok = ^{pacc_q, rx_s2_q};
  assign busy = (st_q != URX_IDLE);

  // bit timing, shifting and framing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= URX_IDLE;
      tcnt_q <= '0;
      bit_q  <= 4'h0;
      shf_q  <= 9'h000;
      pacc_q <= 1'b0;
      pbad_q <= 1'b0;
    end else if (!en_q) begin
      st_q <= URX_IDLE; // halted channel drops the frame [R14]
    end else begin
      if (op_tick) tcnt_q <= latch ? '0 : tcnt_q + 1'b1;
      case (st_q)
        URX_IDLE: begin
          if (fall) begin // start edge, also from device stop in snooze [R17]
            st_q   <= URX_START;
            tcnt_q <= '0; // [R18]
          end
        end
        URX_START: begin
          if (latch) begin
            st_q   <= rx_s2_q ? URX_IDLE : URX_DATA; // glitch is no start
            bit_q  <= 4'h0;
            pacc_q <= 1'b0;
            pbad_q <= 1'b0;
          end
        end
        URX_DATA: begin
          if (latch) begin // lsb first [R10]
            shf_q[bit_q] <= rx_s2_q;
            pacc_q       <= pacc_q ^ rx_s2_q;
            bit_q        <= bit_q + 4'h1;
            if (bit_q == nbits - 4'h1) st_q <= (pmode == PAR_NONE) ? URX_STOP : URX_PARITY;
          end
        end
        URX_PARITY: begin
          if (latch) begin
            pbad_q <= ((pmode == PAR_EVEN) & (pacc_q ^ rx_s2_q))
                    | ((pmode == PAR_ODD) & ~odd_ok);
            st_q   <= URX_STOP;
          end
        end
        URX_STOP: begin
          if (latch) st_q <= URX_IDLE;
        end
        default: st_q <= URX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // two-entry receive buffer
  // ****************************************************************
  logic [8:0]     mem_q [DEPTH];
  logic [PTR_W:0] wp_q, rp_q;
  wire  [8:0]     frame_word = mode_q[MODE_LEN9_BIT] ? shf_q : {1'b0, shf_q[7:0]};
  wire            f_full  = (wp_q[PTR_W] != rp_q[PTR_W]) && (wp_q[PTR_W-1:0] == rp_q[PTR_W-1:0]);
  wire            f_empty = (wp_q == rp_q);
  wire            in_ready  = ~f_full;
  wire            in_valid  = frame_end;
  wire            push      = in_valid & in_ready;
  wire            out_valid = ~f_empty;
  wire            out_ready = ~bff_q & ~(acc & hit_dat & ~pwrite); // no refill mid data read
  wire            pop       = out_valid & out_ready;
  // buffer storage and pointers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_q <= '0;
      rp_q <= '0;
      for (int i = 0; i < DEPTH; i++) mem_q[i] <= 9'h000;
    end else begin
      if (push) begin
        mem_q[wp_q[PTR_W-1:0]] <= frame_word;
        wp_q <= wp_q + 1'b1;
      end
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end
  // data register and buffer full
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 9'h000;
      bff_q   <= 1'b0;
    end else if (pop) begin
      rdata_q <= mem_q[rp_q[PTR_W-1:0]];
      bff_q   <= 1'b1;
    end else if (rd_fire & hit_dat) begin
      bff_q <= 1'b0; // [R12]
    end
  end

  // ****************************************************************
  // error flags and interrupt pulses
  // ****************************************************************
  wire ev_ovr  = in_valid & ~in_ready;
  wire ev_par  = frame_end & pbad_q;
  wire ev_frm  = frame_end & ~rx_s2_q; // low stop sample [R18]
  wire ev_any  = ev_ovr | ev_par | ev_frm;
  wire err_ok  = ~(wake_q & supp_q); // [R6]
  wire clr_wr  = wr_fire & hit_clr;
  // sticky flags: a new error wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovr_q <= 1'b0;
      par_q <= 1'b0;
      frm_q <= 1'b0;
    end else begin
      ovr_q <= (ev_ovr & err_ok) | (ovr_q & ~(clr_wr & pwdata[ST_OVR_BIT])); // [R13] [R6]
      par_q <= (ev_par & err_ok) | (par_q & ~(clr_wr & pwdata[ST_PAR_BIT])); // [R13] [R6]
      frm_q <= (ev_frm & err_ok) | (frm_q & ~(clr_wr & pwdata[ST_FRM_BIT])); // [R13] [R6]
    end
  end
  // one-cycle interrupt and wakeup pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_irq_q <= 1'b0;
      err_irq_q  <= 1'b0;
      wakeup_q   <= 1'b0;
    end else begin
      done_irq_q <= push; // still raised with errors masked [R4]
      err_irq_q  <= ev_any & err_ok & mode_q[MODE_EIE_BIT]; // [R4] [R5]
      wakeup_q   <= wake_q & device_stopped & en_q & (st_q == URX_IDLE) & fall; // [R17]
    end
  end
  assign pready        = pready_q;
  assign prdata        = prdata_q;
  assign pslverr       = pslverr_q;
  assign rx_done_irq   = done_irq_q;
  assign rx_error_irq  = err_irq_q;
  assign snooze_wakeup = wakeup_q;

endmodule : urx_top

// ### src/urx_pkg.sv
// package: register map, field layout and reset values of the serial receive channel
package urx_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_PRESCALER = 8'h00; // prescaler_select_reg
  localparam logic [7:0] OFS_MODE      = 8'h04; // channel_mode_reg
  localparam logic [7:0] OFS_DATA      = 8'h08; // serial_data_divider_reg
  localparam logic [7:0] OFS_STATUS    = 8'h0C; // channel_status_reg
  localparam logic [7:0] OFS_FLAGCLR   = 8'h10; // flag_clear_trigger_reg
  localparam logic [7:0] OFS_START     = 8'h14; // channel start register
  localparam logic [7:0] OFS_STOP      = 8'h18; // channel_stop_reg
  localparam logic [7:0] OFS_ENABLE    = 8'h1C; // channel_enable_status_reg
  localparam logic [7:0] OFS_SNOOZE    = 8'h20; // snooze control register

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PRS0_LSB      = 0;  // prescaler field 0, 4 bits
  localparam int PRS1_LSB      = 4;  // prescaler field 1, 4 bits
  localparam int MODE_PAR_LSB  = 0;  // parity mode, 2 bits
  localparam int MODE_LEN9_BIT = 4;  // 1: nine data bits, 0: eight
  localparam int MODE_EIE_BIT  = 8;  // error_irq_enable
  localparam int MODE_CKS_BIT  = 15; // clock_source_sel
  localparam int DIV_LSB       = 9;  // divider field, bits 15..9
  localparam int ST_OVR_BIT    = 0;  // overrun_error_flag
  localparam int ST_PAR_BIT    = 1;  // parity_error_flag
  localparam int ST_FRM_BIT    = 2;  // framing_error_flag
  localparam int ST_BFF_BIT    = 5;  // rx_buffer_full
  localparam int ST_BUSY_BIT   = 6;  // reception in progress
  localparam int SNZ_WAKE_BIT  = 0;  // snooze_wake_ctrl
  localparam int SNZ_SUPP_BIT  = 1;  // snooze_error_suppress

  // ****************************************************************
  // encodings and reset values
  // ****************************************************************
  localparam logic [1:0] PAR_NONE = 2'h0; // no parity bit
  localparam logic [1:0] PAR_ZERO = 2'h1; // parity bit, not checked
  localparam logic [1:0] PAR_EVEN = 2'h2;
  localparam logic [1:0] PAR_ODD  = 2'h3;

  localparam logic [7:0]  RST_PRESCALER = 8'h00;
  localparam logic [15:0] RST_MODE      = 16'h0000;
  localparam logic [6:0]  RST_DIVIDER   = 7'h7F;

  typedef enum logic [2:0] {
    URX_IDLE, URX_START, URX_DATA, URX_PARITY, URX_STOP
  } urx_state_e;

endpackage : urx_pkg

// ### tb/urx_tx_model.sv
// partner: remote transmitter driving the serial input of the channel
module urx_tx_model (
  input wire logic pclk,
  output logic     rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // frame shifter, line idles high between frames
  // ****************************************************************
  initial rx_pin = 1'b1;

  // n bits lsb first, each held per cycles, same rate as the receiver
  task automatic send(input logic [11:0] frm, input int n, input int per);
    for (int b = 0; b < n; b++) begin
      @(posedge pclk);
      rx_pin <= frm[b];
      repeat (per - 1) @(posedge pclk);
    end
    @(posedge pclk);
    rx_pin <= 1'b1;
  endtask : send
endmodule : urx_tx_model

// ### tb/urx_top_monitor.sv
// checker: port-level timing checks of the serial receive channel
module urx_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        rx_pin,
  input wire logic        device_stopped,
  input wire logic        rx_done_irq,
  input wire logic        rx_error_irq,
  input wire logic        snooze_wakeup
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // helper: cycles since the last falling edge on the serial input
  // ****************************************************************
  logic [7:0] age_q;
  logic [7:0] age_d;
  logic       rx_last_q;

  assign age_d = (rx_last_q && !rx_pin) ? 8'h00 : (age_q == 8'hFF) ? age_q : age_q + 8'h01;

  // saturating age counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      age_q     <= 8'hFF;
      rx_last_q <= 1'b1;
    end else begin
      age_q     <= age_d;
      rx_last_q <= rx_pin;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready not one cycle after access start");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  property p_slverr; pslverr |-> pready; endproperty
  a_slverr: assert property (p_slverr) else $error("pslverr without pready");
  property p_rdzero; !pready |-> prdata == 32'h0; endproperty
  a_rdzero: assert property (p_rdzero) else $error("prdata nonzero outside answer");
  property p_done; rx_done_irq |=> !rx_done_irq; endproperty
  a_done: assert property (p_done) else $error("done pulse too long");
  property p_age; rx_done_irq |-> age_q >= 8'h03; endproperty
  a_age: assert property (p_age) else $error("frame done too soon after edge");
  property p_err; rx_error_irq |=> !rx_error_irq; endproperty
  a_err: assert property (p_err) else $error("error pulse too long");
  property p_wake; snooze_wakeup |-> $past(device_stopped) && age_q <= 8'h08; endproperty
  a_wake: assert property (p_wake) else $error("wakeup without stopped start edge");
endmodule : urx_monitor

bind urx_top urx_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .rx_pin(rx_pin), .device_stopped(device_stopped), .rx_done_irq(rx_done_irq),
  .rx_error_irq(rx_error_irq), .snooze_wakeup(snooze_wakeup));

// ### tb/tb_urx_top.sv
// testbench: register-level checks of the serial receive channel
module tb_urx_top;
  timeunit 1ns;
  timeprecision 1ps;
  import urx_pkg::*;

  // ****************************************************************
  // signals, counters and clock
  // ****************************************************************
  logic        pclk           = 1'b0;
  logic        presetn        = 1'b0;
  logic        psel           = 1'b0;
  logic        penable        = 1'b0;
  logic        pwrite         = 1'b0;
  logic [7:0]  paddr          = 8'h00;
  logic [31:0] pwdata         = 32'h0;
  logic        device_stopped = 1'b0;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        rx_pin;
  logic        rx_done_irq;
  logic        rx_error_irq;
  logic        snooze_wakeup;
  logic [31:0] rdat;
  logic        rerr;
  int          n_fail   = 0;
  int          compares = 0;
  int          n_done   = 0;
  int          n_err    = 0;
  int          n_wake   = 0;
  int          per      = 6;

  always #4 pclk = ~pclk;
  // pulse counters, old values seen at each edge
  always @(posedge pclk) begin
    n_done += (rx_done_irq === 1'b1);
    n_err  += (rx_error_irq === 1'b1);
    n_wake += (snooze_wakeup === 1'b1);
  end

  urx_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .rx_pin(rx_pin), .device_stopped(device_stopped),
    .rx_done_irq(rx_done_irq), .rx_error_irq(rx_error_irq), .snooze_wakeup(snooze_wakeup));
  urx_tx_model u_tx (.pclk(pclk), .rx_pin(rx_pin));

  // ****************************************************************
  // bus and frame tasks
  // ****************************************************************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // pready and the answer are taken at the rising edge that ends the access
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 16);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      summarize();
    end
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rdat & m);
  endtask : rd

  // one 11-bit frame, then count the pulses it produced
  task automatic frame(input logic [7:0] d, input logic pb, input logic sb, input int ed, input int ee);
    int d0;
    int e0;
    int i;
    d0 = n_done;
    e0 = n_err;
    i  = 0;
    u_tx.send({1'b1, sb, pb, d, 1'b0}, 11, per);
    while (n_done == d0 && n_err == e0 && i < 64) begin
      @(posedge pclk);
      i++;
    end
    if (i >= 64) begin
      n_fail++;
      summarize();
    end
    repeat (4) @(posedge pclk);
    if (ed >= 0) chk("done irqs", 32'(ed), 32'(n_done - d0));
    chk("error irqs", 32'(ee), 32'(n_err - e0));
  endtask : frame

  task automatic summarize();
    $display("mismatches %0d comparisons %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int w0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_MODE, 32'hFFFF, {16'h0, RST_MODE}, "mode");
    rd(OFS_PRESCALER, 32'hFF, {24'h0, RST_PRESCALER}, "prescaler");
    rd(OFS_DATA, 32'hFE00, {16'h0, RST_DIVIDER, 9'h0}, "divider");
    rd(OFS_ENABLE, 32'h1, 32'h0, "enable");
    rd(8'h3C, 32'hFFFF_FFFF, 32'h0, "unmapped");
    chk("slverr", 32'h1, {31'h0, rerr});
    wr(OFS_DATA, 32'h400);
    wr(OFS_MODE, 32'h102);
    wr(OFS_START, 32'h1);
    rd(OFS_ENABLE, 32'h1, 32'h1, "enable");
    frame(8'hA5, 1'b0, 1'b1, 1, 0);
    rd(OFS_STATUS, 32'h27, 32'h20, "buffer full");
    rd(OFS_DATA, 32'hFFFF, 32'h4A5, "data");
    rd(OFS_STATUS, 32'h20, 32'h0, "buffer full");
    wr(OFS_STOP, 32'h0000_000F);
    wr(OFS_PRESCALER, 32'h10);
    wr(OFS_MODE, 32'h8102);
    wr(OFS_START, 32'h1);
    per = 12;
    frame(8'h3C, 1'b1, 1'b1, 1, 1);
    rd(OFS_STATUS, 32'h7, 32'h2, "parity flag");
    wr(OFS_FLAGCLR, rdat);
    rd(OFS_STATUS, 32'h7, 32'h0, "flags");
    rd(OFS_DATA, 32'hFF, 32'h3C, "data");
    frame(8'h00, 1'b0, 1'b0, 1, 1);
    rd(OFS_STATUS, 32'h4, 32'h4, "framing flag");
    wr(OFS_STOP, 32'h1);
    rd(OFS_ENABLE, 32'h1, 32'h0, "enable");
    wr(OFS_FLAGCLR, 32'h7);
    apb(1'b0, OFS_DATA, 32'h0);
    wr(OFS_START, 32'h1);
    for (int s = 0; s < 3; s++) begin
      wr(OFS_STOP, 32'h1);
      wr(OFS_MODE, (s == 0) ? 32'h8002 : 32'h8102);
      wr(OFS_SNOOZE, (s == 2) ? 32'h3 : 32'h1);
      wr(OFS_START, 32'h1);
      device_stopped <= 1'b1;
      w0 = n_wake;
      frame(8'h5A, 1'b1, 1'b1, 1, (s == 1) ? 1 : 0);
      chk("wakeups", 32'h1, 32'(n_wake - w0));
      rd(OFS_STATUS, 32'h7, (s == 2) ? 32'h0 : 32'h2, "snooze flags");
      apb(1'b0, OFS_DATA, 32'h0);
      wr(OFS_FLAGCLR, 32'h7);
      wr(OFS_STOP, 32'h1);
      wr(OFS_SNOOZE, 32'h0);
      device_stopped <= 1'b0;
      wr(OFS_START, 32'h1);
    end
    wr(OFS_MODE, 32'h0000_8113);
    // nine data bits, odd parity: pb is data bit 8, sb the parity, idle high the stop
    frame(8'h0F, 1'b1, 1'b0, 1, 0);
    rd(OFS_DATA, 32'h1FF, 32'h10F, "nine-bit data");
    wr(OFS_MODE, 32'h0000_8102);
    // data register and both buffer entries fill, the fourth frame overruns
    for (int f = 0; f < 4; f++) begin
      frame(8'h0F, 1'b0, 1'b1, int'(f < 3), int'(f == 3));
    end
    rd(OFS_STATUS, 32'h21, 32'h21, "overrun flag");
    rd(OFS_DATA, 32'hFF, 32'h0F, "kept word");
    summarize();
  end
endmodule : tb_urx_top
